// *** cfc_pkg.sv ***
package cfc_pkg;
    // ----------------------------------------
    // Bit counts, counter levels, counter steps and reset values
    // ----------------------------------------
    localparam logic [3:0] RUN_LEN = 4'hb;
    localparam logic [7:0] BOFF_SEQS = 8'h80;
    localparam logic [7:0] WARN_LVL = 8'h60;
    localparam logic [7:0] PASV_LVL = 8'h7f;
    localparam logic [3:0] FLAG_LEN = 4'h6;
    localparam logic [3:0] DELIM_LEN = 4'h8;
    localparam logic [3:0] DOM_ACT = 4'he;
    localparam logic [3:0] DOM_PAS = 4'h8;
    localparam logic [3:0] DOM_NEXT = 4'h8;
    localparam logic [2:0] STUFF_LEN = 3'h6;
    localparam logic [3:0] IFS_LEN = 4'h3;
    localparam logic [3:0] OVL_WIN = 4'h2;
    localparam logic [3:0] SUSP_LEN = 4'h8;
    localparam logic [7:0] INC_ONE = 8'h01;
    localparam logic [7:0] INC_BIG = 8'h08;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [4:0] TQ_RST = 5'h00;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        NS_SYNC = 2'b00, NS_ACT = 2'b01, NS_PAS = 2'b10, NS_BOFF = 2'b11
    } cfc_node_t;
    typedef enum logic [2:0] {
        FP_IDLE = 3'b000, FP_ERR = 3'b001, FP_OVL = 3'b010, FP_WAIT = 3'b011,
        FP_DELIM = 3'b100, FP_IFS = 3'b101, FP_SUSP = 3'b110
    } cfc_phase_t;
    typedef struct packed {
        logic in_frame;
        logic txing;
        logic tx_bit;
        logic stuffed;
        logic arb;
        logic stuff_bit;
        logic ack_slot;
        logic ack_delim;
        logic fixed;
        logic fixed_lvl;
        logic crc_chk;
        logic crc_zero;
        logic eof_last;
        logic eof_done;
        logic frame_ok;
    } cfc_frm_t;
    typedef struct packed {
        logic bit_e;
        logic stuff_e;
        logic form_e;
        logic crc_e;
        logic ack_e;
    } cfc_errs_t;
    typedef struct packed {
        logic [4:0] tq;
        logic sample;
        logic tx_point;
    } cfc_btl_t;
    typedef struct packed {
        logic [7:0] cnt;
        logic ovf;
    } cfc_cnt_t;
    typedef struct packed {
        cfc_node_t node;
        cfc_phase_t phase;
        logic [3:0] run;
        logic [7:0] boff;
        logic [2:0] srun;
        logic last;
        logic [3:0] fcnt;
        logic [3:0] dcnt;
        logic [3:0] dthr;
        logic fdom;
        logic is_ovl;
        logic first;
        logic crc_pend;
        logic ack_pend;
        logic pas_dom;
        logic once;
        logic was_tx;
        logic rx_prev;
        logic tx;
        logic drv;
        logic warn;
        logic tx_ok;
        logic ovl;
        cfc_errs_t errs;
        logic rx_inc1;
        logic rx_inc8;
        logic tx_inc8;
        logic rx_dec;
        logic tx_dec;
        logic clr;
    } cfc_st_t;
endpackage

// *** cfc_bit_timing.sv ***
module cfc_bit_timing
    import cfc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic tq_i,
    input wire logic hard_sync_i,
    input wire logic [3:0] seg_a_len_i,
    input wire logic [2:0] seg_b_len_i,
    output logic sample_o,
    output logic tx_point_o
);
    cfc_btl_t st_r, st_nxt;
    logic [4:0] last_tq;

    // Software keeps 1 + seg a + seg b within 4..23 quanta
    assign last_tq = {1'b0, seg_a_len_i} + {2'b00, seg_b_len_i};

    always_comb begin
        st_nxt = st_r;
        st_nxt.sample = 1'b0;
        st_nxt.tx_point = 1'b0;
        if (hard_sync_i) begin
            st_nxt.tq = TQ_RST;
        end else if (tq_i) begin
            st_nxt.tq = st_r.tq + 5'h01;
            if (st_r.tq == {1'b0, seg_a_len_i}) begin
                st_nxt.sample = 1'b1;
            end
            if (st_r.tq >= last_tq) begin
                st_nxt.tx_point = 1'b1;
                st_nxt.tq = TQ_RST;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sample_o = st_r.sample;
    assign tx_point_o = st_r.tx_point;
endmodule // cfc_bit_timing

// *** cfc_err_counter.sv ***
module cfc_err_counter
    import cfc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic inc1_i,
    input wire logic inc8_i,
    input wire logic dec_i,
    input wire logic clr_i,
    input wire logic hold_msb_i,
    output logic [7:0] cnt_o,
    output logic ovf_o
);
    cfc_cnt_t st_r, st_nxt;
    logic [8:0] sum;

    assign sum = {1'b0, st_r.cnt} + {1'b0, inc8_i ? INC_BIG : INC_ONE};

    always_comb begin
        st_nxt = st_r;
        st_nxt.ovf = 1'b0;
        if (clr_i) begin
            st_nxt.cnt = CNT_RST;
        end else if ((inc1_i || inc8_i) && !(hold_msb_i && st_r.cnt[7])) begin
            if (sum[8]) begin
                // Saturate; the carry marks a count above 255
                st_nxt.cnt = 8'hff;
                st_nxt.ovf = 1'b1;
            end else begin
                st_nxt.cnt = sum[7:0];
            end
        end else if (dec_i && st_r.cnt != CNT_RST) begin
            st_nxt.cnt = st_r.cnt - 8'h01;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cnt_o = st_r.cnt;
    assign ovf_o = st_r.ovf;
endmodule // cfc_err_counter

// *** cfc_fault_confinement.sv ***
// Operation
// - Overload frame is six dominant flag bits then eight recessive delimiter bits.
// - Never start own overload; answer others' overload after end of frame.
// - At least three intermission bits before data or remote frames only.
// - Transmitter flags bus/sent mismatch, except passive flag, arbitration, ack slot.
// - Six equal bits inside a stuffed field raise a stuff error.
// - Wrong fixed-form bit is a form error; receiver accepts dominant last EOF.
// - Nonzero CRC remainder is CRC error; missing dominant ack is ack error.
// - After enable or wake-up wait eleven recessive bits, then go error active.
// - Warning is set while active or passive; left when both counters below 96.
// - Passive above 127 with one active flag first; active again below 128.
// - Transmit count above 255 gives bus off with drivers disabled.
// - Bus off ends after 128 runs of eleven recessive bits; counters cleared.
// - Both 8-bit counters readable together as one 16-bit value.
// - Plus 8 for bit error in active flag or receiver's dominant first bit after error flag.
// - Plus 8 at 14th dominant after active flag, 8th after passive, each 8 more.
// - Other errors add 1 to receive count or 8 to transmit count.
// - Successful frame subtracts 1 from its counter unless already zero.
// - Receive counter stops incrementing while its top bit is set.
// - No transmit increment for arbitration stuff-bit error or passive silent ack error.
// - Bit is sync, segment a, segment b; sample between, transmit at end.
// - Segment a length from a 4-bit field, segment b from a 3-bit field.
// - Error flag starts next bit; for CRC error after ack delimiter.
// - Error flag field may span six to twelve bits from overlapping flags.
module cfc_fault_confinement
    import cfc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic enable_i,
    input wire logic wake_i,
    input wire logic tq_i,
    input wire logic [3:0] phase_seg_a_len_i,
    input wire logic [2:0] phase_seg_b_len_i,
    input wire logic rx_i,
    input cfc_frm_t frm_i,
    output logic tx_o,
    output logic drivers_en_o,
    output logic sample_o,
    output logic tx_point_o,
    output cfc_node_t node_state_o,
    output logic err_warning_o,
    output logic [15:0] fault_count_reg_o,
    output cfc_errs_t err_o,
    output logic overload_o,
    output logic tx_start_ok_o
);
    cfc_st_t st_r, st_nxt;
    logic [7:0] rx_fault_count;
    logic [7:0] tx_fault_count;
    logic tx_ovf;
    logic sample;
    logic tx_point;
    logic hard_sync;
    logic part;
    logic pas_lvl;
    logic run_hit;
    logic err_hit;
    logic ovl_hit;
    logic who_tx;
    logic [2:0] srun_nxt;

    function automatic logic [3:0] bump(input logic [3:0] v);
        return v + 4'h1;
    endfunction

    function automatic logic above(input logic [7:0] v, input logic [7:0] lvl);
        return v > lvl;
    endfunction

    // ----------------------------------------
    // Bit timing and counters
    // ----------------------------------------
    // Bus idle falling edge restarts the bit so sampling lines up with start of frame
    assign hard_sync = st_r.phase == FP_IDLE && !frm_i.in_frame && st_r.rx_prev && !rx_i;

    cfc_bit_timing u_btl (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .tq_i(tq_i),
        .hard_sync_i(hard_sync),
        .seg_a_len_i(phase_seg_a_len_i),
        .seg_b_len_i(phase_seg_b_len_i),
        .sample_o(sample),
        .tx_point_o(tx_point)
    );

    cfc_err_counter u_rx_cnt (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .inc1_i(st_r.rx_inc1),
        .inc8_i(st_r.rx_inc8),
        .dec_i(st_r.rx_dec),
        .clr_i(st_r.clr),
        .hold_msb_i(1'b1),
        .cnt_o(rx_fault_count),
        .ovf_o()
    );

    cfc_err_counter u_tx_cnt (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .inc1_i(1'b0),
        .inc8_i(st_r.tx_inc8),
        .dec_i(st_r.tx_dec),
        .clr_i(st_r.clr),
        .hold_msb_i(1'b0),
        .cnt_o(tx_fault_count),
        .ovf_o(tx_ovf)
    );

    assign part = st_r.node == NS_ACT || st_r.node == NS_PAS;
    assign pas_lvl = above(rx_fault_count, PASV_LVL) || above(tx_fault_count, PASV_LVL);
    assign run_hit = sample && rx_i && st_r.run == RUN_LEN - 4'h1;
    assign who_tx = st_r.phase == FP_IDLE ? frm_i.txing : st_r.was_tx;
    assign srun_nxt = (rx_i == st_r.last && st_r.srun != 3'h0) ? st_r.srun + 3'h1 : 3'h1;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.errs = '0;
        st_nxt.ovl = 1'b0;
        st_nxt.rx_inc1 = 1'b0;
        st_nxt.rx_inc8 = 1'b0;
        st_nxt.tx_inc8 = 1'b0;
        st_nxt.rx_dec = 1'b0;
        st_nxt.tx_dec = 1'b0;
        st_nxt.clr = 1'b0;
        st_nxt.rx_prev = rx_i;
        err_hit = 1'b0;
        ovl_hit = 1'b0;

        if (sample) begin
            st_nxt.run = rx_i ? bump(st_r.run) : 4'h0;
            if (run_hit) begin
                st_nxt.run = 4'h0;
            end
        end

        // Node state
        unique case (st_r.node)
            NS_SYNC: begin
                if (run_hit) begin
                    st_nxt.node = NS_ACT;
                    st_nxt.phase = FP_IDLE;
                end
            end
            NS_ACT: begin
                if (tx_ovf) begin
                    st_nxt.node = NS_BOFF;
                end else if (pas_lvl) begin
                    st_nxt.node = NS_PAS;
                    // The flag already running is the one active flag
                    st_nxt.once = st_r.phase != FP_ERR;
                end
            end
            NS_PAS: begin
                if (tx_ovf) begin
                    st_nxt.node = NS_BOFF;
                end else if (!pas_lvl) begin
                    st_nxt.node = NS_ACT;
                    st_nxt.once = 1'b0;
                end
            end
            NS_BOFF: begin
                if (run_hit) begin
                    st_nxt.boff = st_r.boff + 8'h01;
                    if (st_r.boff + 8'h01 == BOFF_SEQS) begin
                        st_nxt.node = NS_ACT;
                        st_nxt.clr = 1'b1;
                        st_nxt.boff = 8'h00;
                    end
                end
            end
        endcase
        if (st_nxt.node == NS_BOFF && st_r.node != NS_BOFF) begin
            st_nxt.phase = FP_IDLE;
            st_nxt.boff = 8'h00;
            st_nxt.run = 4'h0;
        end

        // Frame and flag sequencing, one step per sampled bit
        if (sample && part && !tx_ovf) begin
            unique case (st_r.phase)
                FP_IDLE: begin
                    if (frm_i.in_frame) begin
                        if (frm_i.stuffed) begin
                            st_nxt.srun = srun_nxt;
                            st_nxt.last = rx_i;
                            if (srun_nxt == STUFF_LEN) begin
                                st_nxt.errs.stuff_e = 1'b1;
                            end
                        end else begin
                            st_nxt.srun = 3'h0;
                        end
                        if (frm_i.txing && rx_i != frm_i.tx_bit
                            && !(!rx_i && (frm_i.arb || frm_i.ack_slot))) begin
                            st_nxt.errs.bit_e = 1'b1;
                        end
                        if (frm_i.fixed && rx_i != frm_i.fixed_lvl
                            && !(frm_i.eof_last && !frm_i.txing)) begin
                            st_nxt.errs.form_e = 1'b1;
                        end
                        if (frm_i.txing && frm_i.ack_slot && rx_i) begin
                            st_nxt.errs.ack_e = 1'b1;
                        end
                        if (frm_i.crc_chk && !frm_i.crc_zero && !frm_i.txing) begin
                            st_nxt.crc_pend = 1'b1;
                        end
                        err_hit = st_nxt.errs.stuff_e || st_nxt.errs.bit_e
                            || st_nxt.errs.form_e || st_nxt.errs.ack_e;
                        if (!err_hit && frm_i.ack_delim && st_r.crc_pend) begin
                            st_nxt.errs.crc_e = 1'b1;
                            err_hit = 1'b1;
                        end
                        if (err_hit) begin
                            if (!frm_i.txing) begin
                                st_nxt.rx_inc1 = 1'b1;
                            end else if (st_nxt.errs.stuff_e && frm_i.arb
                                && frm_i.stuff_bit && frm_i.tx_bit) begin
                                st_nxt.tx_inc8 = 1'b0;
                            end else if (st_nxt.errs.ack_e && st_r.node == NS_PAS) begin
                                st_nxt.ack_pend = 1'b1;
                            end else begin
                                st_nxt.tx_inc8 = 1'b1;
                            end
                        end else begin
                            if (frm_i.eof_last && !frm_i.txing && !rx_i) begin
                                ovl_hit = 1'b1;
                            end
                            if (frm_i.frame_ok) begin
                                st_nxt.tx_dec = frm_i.txing;
                                st_nxt.rx_dec = !frm_i.txing;
                            end
                            if (frm_i.eof_done && !ovl_hit) begin
                                st_nxt.phase = FP_IFS;
                                st_nxt.fcnt = 4'h0;
                                st_nxt.was_tx = frm_i.txing;
                                st_nxt.crc_pend = 1'b0;
                            end
                        end
                    end else begin
                        st_nxt.srun = 3'h0;
                        st_nxt.crc_pend = 1'b0;
                    end
                end
                FP_ERR, FP_OVL: begin
                    st_nxt.fcnt = bump(st_r.fcnt);
                    if (st_r.phase == FP_ERR && st_r.fdom && rx_i) begin
                        st_nxt.errs.bit_e = 1'b1;
                        st_nxt.rx_inc8 = !st_r.was_tx;
                        st_nxt.tx_inc8 = st_r.was_tx;
                    end
                    if (!st_r.fdom && !rx_i) begin
                        st_nxt.pas_dom = 1'b1;
                    end
                    if (bump(st_r.fcnt) == FLAG_LEN) begin
                        st_nxt.phase = FP_WAIT;
                        st_nxt.dcnt = 4'h0;
                        st_nxt.dthr = st_r.fdom ? DOM_ACT : DOM_PAS;
                        st_nxt.first = 1'b1;
                        st_nxt.ack_pend = 1'b0;
                        if (st_r.ack_pend && (st_r.pas_dom || !rx_i)) begin
                            st_nxt.tx_inc8 = 1'b1;
                        end
                    end
                end
                FP_WAIT: begin
                    st_nxt.first = 1'b0;
                    if (rx_i) begin
                        // First recessive bit is delimiter bit one
                        st_nxt.phase = FP_DELIM;
                        st_nxt.fcnt = 4'h1;
                    end else begin
                        if (st_r.first && !st_r.was_tx && !st_r.is_ovl) begin
                            st_nxt.rx_inc8 = 1'b1;
                        end
                        st_nxt.dcnt = bump(st_r.dcnt);
                        if (bump(st_r.dcnt) == st_r.dthr) begin
                            st_nxt.rx_inc8 = !st_r.was_tx;
                            st_nxt.tx_inc8 = st_r.was_tx;
                            st_nxt.dcnt = 4'h0;
                            st_nxt.dthr = DOM_NEXT;
                        end
                    end
                end
                FP_DELIM: begin
                    st_nxt.fcnt = bump(st_r.fcnt);
                    if (!rx_i) begin
                        st_nxt.errs.form_e = 1'b1;
                        st_nxt.rx_inc1 = !st_r.was_tx;
                        st_nxt.tx_inc8 = st_r.was_tx;
                        err_hit = 1'b1;
                    end else if (bump(st_r.fcnt) == DELIM_LEN) begin
                        st_nxt.phase = FP_IFS;
                        st_nxt.fcnt = 4'h0;
                    end
                end
                FP_IFS: begin
                    st_nxt.fcnt = bump(st_r.fcnt);
                    if (!rx_i) begin
                        if (st_r.fcnt < OVL_WIN) begin
                            ovl_hit = 1'b1;
                        end else begin
                            // Start of frame from another node on the last bit
                            st_nxt.phase = FP_IDLE;
                        end
                    end else if (bump(st_r.fcnt) == IFS_LEN) begin
                        st_nxt.fcnt = 4'h0;
                        st_nxt.phase = (st_r.node == NS_PAS && st_r.was_tx) ? FP_SUSP : FP_IDLE;
                    end
                end
                FP_SUSP: begin
                    st_nxt.fcnt = bump(st_r.fcnt);
                    if (!rx_i || bump(st_r.fcnt) == SUSP_LEN) begin
                        st_nxt.phase = FP_IDLE;
                    end
                end
                default: begin
                    st_nxt.phase = FP_IDLE;
                end
            endcase

            // Error and overload frames go out at once, no intermission
            if (err_hit) begin
                st_nxt.phase = FP_ERR;
                st_nxt.fcnt = 4'h0;
                st_nxt.fdom = st_r.node == NS_ACT || st_r.once;
                st_nxt.once = 1'b0;
                st_nxt.is_ovl = 1'b0;
                st_nxt.pas_dom = 1'b0;
                st_nxt.crc_pend = 1'b0;
                st_nxt.was_tx = who_tx;
            end else if (ovl_hit) begin
                st_nxt.phase = FP_OVL;
                st_nxt.fcnt = 4'h0;
                st_nxt.fdom = 1'b1;
                st_nxt.is_ovl = 1'b1;
                st_nxt.was_tx = 1'b0;
                st_nxt.ovl = 1'b1;
            end
        end

        if (!enable_i || wake_i) begin
            st_nxt.node = NS_SYNC;
            st_nxt.phase = FP_IDLE;
            st_nxt.run = 4'h0;
            st_nxt.once = 1'b0;
            st_nxt.ack_pend = 1'b0;
            st_nxt.crc_pend = 1'b0;
        end

        // ----------------------------------------
        // Pin and status outputs
        // ----------------------------------------
        if (tx_point) begin
            if (!part) begin
                st_nxt.tx = 1'b1;
            end else if (st_r.phase == FP_ERR || st_r.phase == FP_OVL) begin
                st_nxt.tx = !st_r.fdom;
            end else if (st_r.phase == FP_IDLE && frm_i.in_frame && frm_i.txing) begin
                st_nxt.tx = frm_i.tx_bit;
            end else begin
                st_nxt.tx = 1'b1;
            end
        end
        if (st_nxt.node == NS_BOFF || st_nxt.node == NS_SYNC) begin
            st_nxt.tx = 1'b1;
        end
        st_nxt.drv = st_nxt.node == NS_ACT || st_nxt.node == NS_PAS;
        st_nxt.warn = st_nxt.drv && (rx_fault_count >= WARN_LVL || tx_fault_count >= WARN_LVL);
        st_nxt.tx_ok = st_nxt.drv && st_nxt.phase == FP_IDLE && !frm_i.in_frame;
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            st_r <= '0;
            st_r.tx <= 1'b1;
            st_r.rx_prev <= 1'b1;
            st_r.dthr <= DOM_ACT;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tx_o = st_r.tx;
    assign drivers_en_o = st_r.drv;
    assign sample_o = sample;
    assign tx_point_o = tx_point;
    assign node_state_o = st_r.node;
    assign err_warning_o = st_r.warn;
    assign fault_count_reg_o = {tx_fault_count, rx_fault_count};
    assign err_o = st_r.errs;
    assign overload_o = st_r.ovl;
    assign tx_start_ok_o = st_r.tx_ok;
endmodule // cfc_fault_confinement

// *** cfc_fc_monitor.sv ***
module cfc_fc_monitor
    import cfc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic rx_i,
    input cfc_frm_t frm_i,
    input wire logic tx_o,
    input wire logic drivers_en_o,
    input wire logic sample_o,
    input wire logic tx_point_o,
    input cfc_node_t node_state_o,
    input wire logic [15:0] fault_count_reg_o,
    input cfc_errs_t err_o,
    input wire logic overload_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // One cycle of slack: state and drivers register together
    quiet_off_a: assert property ((node_state_o == NS_SYNC || node_state_o == NS_BOFF)[*2] |-> tx_o && !drivers_en_o)
        else $error("driving while not participating");
    tx_at_point_a: assert property ($changed(tx_o) && $past(drivers_en_o) && drivers_en_o |-> $past(tx_point_o))
        else $error("bus level changed off the transmit point");
    sample_pulse_a: assert property (sample_o |=> !sample_o)
        else $error("sample pulse too long");
    stuff_cause_a: assert property (err_o.stuff_e |-> $past(sample_o) && $past(frm_i.stuffed))
        else $error("stuff error without cause");
    // The flag waits for the ack delimiter, so the cause is the delimiter sample
    crc_cause_a: assert property (err_o.crc_e |-> $past(sample_o) && $past(frm_i.ack_delim))
        else $error("crc error without cause");
    ack_cause_a: assert property (err_o.ack_e |-> $past(frm_i.txing) && $past(frm_i.ack_slot) && $past(rx_i))
        else $error("ack error without cause");
    rx_hold_a: assert property ($past(fault_count_reg_o[7]) |-> fault_count_reg_o[7:0] <= $past(fault_count_reg_o[7:0]))
        else $error("receive count rose while passive");
    boff_clear_a: assert property ($past(node_state_o) == NS_BOFF && node_state_o == NS_ACT |-> ##[0:2] fault_count_reg_o == 16'h0000)
        else $error("counts not cleared leaving bus off");
    ovl_cause_a: assert property (overload_o |-> $past(sample_o) && !$past(rx_i))
        else $error("overload answer without dominant bit");
endmodule // cfc_fc_monitor
bind cfc_fault_confinement cfc_fc_monitor cfc_fc_monitor_inst (.*);

// *** cfc_bus_peer.sv ***
module cfc_bus_peer (
    input wire logic dut_tx_i,
    input wire logic dut_en_i,
    input wire logic dom_i,
    output logic bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wired-AND with pull-up: a released driver reads recessive
    assign bus_o = (dut_tx_i | ~dut_en_i) & ~dom_i;
endmodule // cfc_bus_peer

// *** testbench.sv ***
module testbench
    import cfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, resetn_i = 0, enable_i = 0, wake_i = 0, tq_i = 1, dom = 0, rx_i;
    logic [3:0] phase_seg_a_len_i = 4'h3;
    logic [2:0] phase_seg_b_len_i = 3'h2;
    cfc_frm_t frm_i = '0, idle = '0, sf, of, ov, af;
    logic tx_o, drivers_en_o, sample_o, tx_point_o, err_warning_o, overload_o, tx_start_ok_o;
    cfc_node_t node_state_o;
    logic [15:0] fault_count_reg_o;
    cfc_errs_t err_o;
    int n_errors = 0, compares = 0;
    always #50 mclk_i = ~mclk_i;
    cfc_fault_confinement cfc_fault_confinement_inst (.*);
    cfc_bus_peer cfc_bus_peer_inst (.dut_tx_i(tx_o), .dut_en_i(drivers_en_o), .dom_i(dom), .bus_o(rx_i));
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    // Hold bus level and context through k sample points
    task b(input logic d, input cfc_frm_t f, input int k);
        repeat (k) begin
            dom = d;
            frm_i = f;
            @(negedge mclk_i);
            while (sample_o !== 1'b1) @(negedge mclk_i);
            @(negedge mclk_i);
        end
    endtask
    task flag(input logic l);
        for (int i = 0; i < 7; i++) begin
            b(0, idle, 1);
            chk("flag bit", tx_o, i < 6 ? {15'h0, l} : 16'h1);
        end
    endtask
    task stop_test;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #1ms;
        n_errors++;
        stop_test;
    end
    initial begin
        sf = idle; sf.in_frame = 1; sf.stuffed = 1;
        of = idle; of.in_frame = 1; of.eof_done = 1; of.frame_ok = 1;
        ov = idle; ov.in_frame = 1; ov.eof_last = 1;
        af = idle; af.in_frame = 1; af.txing = 1; af.tx_bit = 1; af.ack_slot = 1;
        repeat (6) @(negedge mclk_i);
        resetn_i = 1;
        chk("node", node_state_o, NS_SYNC);
        chk("tx", tx_o, 16'h1);
        chk("count", fault_count_reg_o, 16'h0);
        enable_i = 1;
        b(0, idle, 10);
        chk("node", node_state_o, NS_SYNC);
        b(0, idle, 3);
        chk("node", node_state_o, NS_ACT);
        $display("test sync done");
        b(1, sf, 6);
        chk("stuff", err_o.stuff_e, 16'h1);
        @(negedge mclk_i);
        chk("count", fault_count_reg_o, 16'h0001);
        flag(0);
        chk("start ok", tx_start_ok_o, 16'h0);
        b(0, idle, 12);
        chk("start ok", tx_start_ok_o, 16'h1);
        repeat (2) begin
            b(0, of, 1);
            b(0, idle, 3);
            chk("count", fault_count_reg_o, 16'h0);
        end
        $display("test stuff done");
        b(1, ov, 1);
        chk("overload", overload_o, 16'h1);
        chk("form", err_o.form_e, 16'h0);
        flag(0);
        b(0, idle, 12);
        b(0, af, 1);
        chk("ack", err_o.ack_e, 16'h1);
        @(negedge mclk_i);
        chk("count", fault_count_reg_o, 16'h0800);
        flag(0);
        $display("test overload ack done");
        repeat (11) begin
            b(0, idle, 12);
            b(0, af, 1);
            flag(0);
        end
        chk("warning", err_warning_o, 16'h1);
        chk("count", fault_count_reg_o, 16'h6000);
        // Last one crosses 127 while its flag already runs dominant
        repeat (4) begin
            b(0, idle, 12);
            b(0, af, 1);
            flag(0);
        end
        chk("node", node_state_o, NS_PAS);
        // Passive transmitter adds the suspend bits
        b(0, idle, 12);
        chk("start ok", tx_start_ok_o, 16'h0);
        b(0, idle, 8);
        chk("start ok", tx_start_ok_o, 16'h1);
        b(1, sf, 6);
        chk("stuff", err_o.stuff_e, 16'h1);
        flag(1);
        b(0, idle, 12);
        of.txing = 1;
        of.tx_bit = 1;
        b(0, of, 1);
        b(0, idle, 3);
        chk("node", node_state_o, NS_ACT);
        chk("count", fault_count_reg_o, 16'h7f01);
        chk("warning", err_warning_o, 16'h1);
        $display("test passive done");
        wake_i = 1;
        @(negedge mclk_i);
        wake_i = 0;
        chk("node", node_state_o, NS_SYNC);
        chk("drivers", drivers_en_o, 16'h0);
        $display("test wake done");
        stop_test;
    end
endmodule // testbench
